// >>> hw/sram_host_defines.svh
`ifndef SRAM_HOST_DEFINES_SVH
`define SRAM_HOST_DEFINES_SVH

// ============================================================
// Geometry of the memory behind each port.
`define ADDR_WIDTH 11
`define DATA_WIDTH 8
`define PORT_COUNT 4

// ============================================================
// Timing, figures in ns, counts at 100 MHz.
`define CLK_PERIOD_NS 10
`define WRITE_PULSE_NS 30
`define WRITE_HOLD_AFTER_BLOCK_NS 20
`define OUTPUT_OFF_NS 15
`define DATA_SETUP_NS 20
`define READ_ACCESS_NS 35
`define CYCLES_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WRITE_PULSE_CYCLES `CYCLES_UP(`OUTPUT_OFF_NS + `DATA_SETUP_NS)
`define HOLD_CYCLES `CYCLES_UP(`WRITE_HOLD_AFTER_BLOCK_NS)
`define READ_CYCLES `CYCLES_UP(`READ_ACCESS_NS)

`endif

// >>> hw/sram_host_pkg.sv
package sram_host_pkg;

  // ============================================================
  // Pin group of one memory port.
  typedef struct packed {
    logic select_n;
    logic drive_n;
    logic read_write;
    logic [10:0] addr;
    logic [7:0] data_out;
    logic data_oe;
  } pins_type;

  // ============================================================
  // Sequencer states.
  typedef enum logic [2:0] {
    idle, addr_setup, write_pulse, write_hold, read_wait, finish
  } state_type;

endpackage

// >>> hw/sram_port_timer.sv
`timescale 1ns/100ps
`include "sram_host_defines.svh"

module sram_port_timer #(
  parameter int WIDTH = 4
) (
  input wire logic clk, // Clock.
  input wire logic resetn, // Synchronous reset, low.
  input wire logic load, // Load a new count.
  input wire logic [WIDTH-1:0] value, // Count to load.
  output logic done // High when the count reaches zero.
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  // ============================================================
  // Down counter; done is derived so it rises the cycle it hits zero.
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done = (count == '0) && !load;

endmodule

// >>> hw/sram_port_host.sv
`timescale 1ns/100ps
`include "sram_host_defines.svh"

module sram_port_host #(
  parameter int ADDR_WIDTH = `ADDR_WIDTH,
  parameter int DATA_WIDTH = `DATA_WIDTH
) (
  input wire logic clk, // Clock, 100 MHz.
  input wire logic resetn, // Synchronous reset, low.
  input wire logic req, // Start an access, one-cycle pulse.
  input wire logic req_write, // High for write.
  input wire logic [ADDR_WIDTH-1:0] req_addr, // Access address.
  input wire logic [DATA_WIDTH-1:0] req_wdata, // Write data.
  output logic busy, // Access in progress.
  output logic done, // Access finished, one-cycle pulse.
  output logic [DATA_WIDTH-1:0] rdata, // Read data, valid with done.
  output logic select_n, // Port select, low active.
  output logic drive_n, // Port output drive, low active.
  output logic read_write, // High read, low write.
  output logic [ADDR_WIDTH-1:0] addr, // Port address.
  output logic [DATA_WIDTH-1:0] data_out, // Data toward the port.
  output logic data_oe, // High while host drives data.
  input wire logic [DATA_WIDTH-1:0] data_in, // Data from the port.
  input wire logic write_block_n // Write block, low suppresses writes.
);

  sram_host_pkg::state_type state, next_state;
  logic [DATA_WIDTH-1:0] next_rdata;
  logic next_busy, next_done, next_select_n, next_drive_n, next_read_write, next_data_oe;
  logic [ADDR_WIDTH-1:0] next_addr;
  logic [DATA_WIDTH-1:0] next_data_out;
  logic timer_load;
  logic [3:0] timer_value;
  logic timer_done;

  // ============================================================
  // Shared timer for pulse width, hold and read access.
  sram_port_timer #(.WIDTH(4)) timer (
    .clk(clk),
    .resetn(resetn),
    .load(timer_load),
    .value(timer_value),
    .done(timer_done)
  );

  // ============================================================
  // Sequencer. Address is set one cycle before select falls so it never
  // moves during a write and is valid before a read starts.
  always_comb begin
    next_state = state;
    next_busy = busy;
    next_done = 1'b0;
    next_rdata = rdata;
    next_select_n = select_n;
    next_drive_n = drive_n;
    next_read_write = read_write;
    next_addr = addr;
    next_data_out = data_out;
    next_data_oe = data_oe;
    timer_load = 1'b0;
    timer_value = 4'h0;
    case (state)
      sram_host_pkg::idle: begin
        next_select_n = 1'b1;
        next_drive_n = 1'b1;
        next_read_write = 1'b1;
        if (req) begin
          next_addr = req_addr;
          next_data_out = req_wdata;
          next_busy = 1'b1;
          next_read_write = !req_write;
          next_data_oe = req_write;
          next_state = sram_host_pkg::addr_setup;
        end
      end
      sram_host_pkg::addr_setup: begin
        next_select_n = 1'b0;
        timer_load = 1'b1;
        if (!read_write) begin
          timer_value = 4'(`WRITE_PULSE_CYCLES);
          next_state = sram_host_pkg::write_pulse;
        end else begin
          next_drive_n = 1'b0;
          timer_value = 4'(`READ_CYCLES);
          next_state = sram_host_pkg::read_wait;
        end
      end
      sram_host_pkg::write_pulse: begin
        if (!write_block_n) begin
          timer_load = 1'b1;
          timer_value = 4'(`HOLD_CYCLES);
        end else if (timer_done) begin
          next_state = sram_host_pkg::write_hold;
        end
      end
      sram_host_pkg::write_hold: begin
        next_select_n = 1'b1;
        next_read_write = 1'b1;
        next_state = sram_host_pkg::finish;
      end
      sram_host_pkg::read_wait: begin
        if (timer_done) begin
          next_rdata = data_in;
          next_select_n = 1'b1;
          next_drive_n = 1'b1;
          next_state = sram_host_pkg::finish;
        end
      end
      sram_host_pkg::finish: begin
        next_data_oe = 1'b0;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = sram_host_pkg::idle;
      end
      default: begin
        next_state = sram_host_pkg::idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state <= sram_host_pkg::idle;
      busy <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
      select_n <= 1'b1;
      drive_n <= 1'b1;
      read_write <= 1'b1;
      addr <= '0;
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      state <= next_state;
      busy <= next_busy;
      done <= next_done;
      rdata <= next_rdata;
      select_n <= next_select_n;
      drive_n <= next_drive_n;
      read_write <= next_read_write;
      addr <= next_addr;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
    end
  end

  // ============================================================
  // Checks on the pin sequencing.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_write_open;
    !select_n && !read_write;
  endsequence

  a_addr_stable: assert property (s_write_open |-> $stable(addr))
    else $error("address moved during write");
  a_drive_write: assert property (!read_write |-> drive_n)
    else $error("drive low during write");
  a_idle_deselect: assert property (!busy |-> select_n)
    else $error("selected while idle");
  a_rw_first: assert property ($fell(select_n) && !read_write |-> $past(!read_write))
    else $error("select fell before read/write");
  a_pulse_width: assert property ($rose(select_n) && $past(!read_write) |->
      $past(!select_n, 4))
    else $error("write pulse too short");
  a_write_data: assert property (s_write_open |-> data_oe)
    else $error("write without data");
  a_block_hold: assert property (($rose(write_block_n) and s_write_open) |->
      (!select_n)[*2])
    else $error("write hold after block too short");
  a_done_follow: assert property ($fell(busy) |-> done)
    else $error("done missing");

endmodule

// >>> testbench/sram_port_model.sv
`timescale 1ns/100ps

// ============================================================
// One port of the memory, as seen from the host.
module sram_port_model (
  input wire logic clk, // Clock.
  input wire logic select_n, // Port select.
  input wire logic drive_n, // Output drive.
  input wire logic read_write, // High read.
  input wire logic [10:0] addr, // Address.
  input wire logic [7:0] data_out, // Data from host.
  input wire logic data_oe, // Host drives data.
  input wire logic write_block_n, // Write block.
  output logic [7:0] data_in // Data to host.
);
  logic [7:0] mem [0:2047];
  logic [7:0] last = 8'h00;

  // Store only in the overlap of select and write, and only while unblocked.
  always @(posedge clk) begin
    if (!select_n && !read_write && write_block_n && data_oe) begin
      mem[addr] <= data_out;
    end
  end

  // Floating pins show the inverse of the last byte, so a stale sample fails.
  always @(posedge clk) begin
    if (!select_n && read_write && !drive_n) begin
      data_in <= mem[addr];
      last <= mem[addr];
    end else begin
      data_in <= ~last;
    end
  end
endmodule

// >>> testbench/sram_port_host_tb.sv
`timescale 1ns/100ps
`include "sram_host_defines.svh"

// ============================================================
// Bench for one port host against the port model.
module sram_port_host_tb;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [10:0] req_addr = 11'h000;
  logic [7:0] req_wdata = 8'h00;
  logic write_block_n = 1'b1;
  logic busy, done, select_n, drive_n, read_write, data_oe;
  logic [7:0] rdata, data_out, data_in;
  logic [10:0] addr;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int lat_w, lat_b, lat_r;

  always #5 clk = ~clk;

  sram_port_host i_sram_port_host (.clk(clk), .resetn(resetn), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .busy(busy),
    .done(done), .rdata(rdata), .select_n(select_n), .drive_n(drive_n),
    .read_write(read_write), .addr(addr), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .write_block_n(write_block_n));

  // This host is the only writer of the memory, so two writers never meet on one address.
  sram_port_model i_sram_port_model (.clk(clk), .select_n(select_n), .drive_n(drive_n),
    .read_write(read_write), .addr(addr), .data_out(data_out), .data_oe(data_oe),
    .write_block_n(write_block_n), .data_in(data_in));

  task check(input string name, input logic [10:0] seen, input logic [10:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task final_report;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the hundred or so cycles the tests need.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      final_report();
    end
  end

  // The host must never drive data while it lets the port drive.
  // Sampled just after the edge, so the registered outputs have settled.
  always @(posedge clk) begin
    #1;
    if (resetn && drive_n === 1'b0) begin
      check("oe_vs_drive", {10'h000, data_oe}, 11'h000);
    end
  end

  task access(input logic w, input logic [10:0] a, input logic [7:0] d, output int lat);
    int n;
    @(posedge clk);
    #1;
    req = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(posedge clk);
    #1;
    req = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 60) begin
      @(posedge clk);
      #1;
      n++;
    end
    lat = n;
  endtask

  task t_reset;
    check("idle_pins", {7'h00, select_n, drive_n, read_write, data_oe}, 11'h00e);
    check("idle_busy", {9'h000, busy, done}, 11'h000);
  endtask

  // Extremes of the address range, written back to back and read back.
  task t_edges;
    access(1'b1, 11'h7ff, 8'ha5, lat_w);
    access(1'b1, 11'h000, 8'h5a, lat_w);
    access(1'b0, 11'h7ff, 8'h00, lat_r);
    check("rd_top", {3'h0, rdata}, 11'h0a5);
    access(1'b0, 11'h000, 8'h00, lat_r);
    check("rd_bottom", {3'h0, rdata}, 11'h05a);
    // Around the timer: a request, an address set-up, a select and a finish cycle; writes
    // add one release cycle.
    check("rd_lat", 11'(lat_r), 11'(`READ_CYCLES + 4));
    check("wr_lat", 11'(lat_w), 11'(`WRITE_PULSE_CYCLES + 5));
  endtask

  // Block a write as its pulse begins; it must still land, and only after the release.
  task t_block;
    fork
      access(1'b1, 11'h123, 8'h3c, lat_b);
      begin
        repeat (3) @(posedge clk);
        #1;
        write_block_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        write_block_n = 1'b1;
      end
    join
    // The block lifts after the plain pulse would have ended, so the hold time is added.
    check("blk_longer", {10'h000, lat_b >= lat_w + `HOLD_CYCLES}, 11'h001);
    access(1'b0, 11'h123, 8'h00, lat_r);
    check("blk_data", {3'h0, rdata}, 11'h03c);
  endtask

  // A block held through a read leaves the read untouched.
  task t_block_read;
    write_block_n = 1'b0;
    access(1'b0, 11'h7ff, 8'h00, lat_r);
    write_block_n = 1'b1;
    check("blk_read", {3'h0, rdata}, 11'h0a5);
  endtask

  // Reset in mid-write drops the port back to standby, and the next read still works.
  task t_reset_mid;
    @(posedge clk);
    #1;
    req = 1'b1;
    req_write = 1'b1;
    req_addr = 11'h055;
    req_wdata = 8'h77;
    @(posedge clk);
    #1;
    req = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("mid_select", {10'h000, select_n}, 11'h000);
    resetn = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("mid_pins", {7'h00, select_n, drive_n, read_write, data_oe}, 11'h00e);
    check("mid_busy", {9'h000, busy, done}, 11'h000);
    resetn = 1'b1;
    access(1'b0, 11'h7ff, 8'h00, lat_r);
    check("mid_read", {3'h0, rdata}, 11'h0a5);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    t_reset();
    resetn = 1'b1;
    t_edges();
    t_block();
    t_block_read();
    t_reset_mid();
    final_report();
  end
endmodule
